// *** inc/rmsel_regs.svh ***
// Register offsets, field positions, codes and reset values of the pin selectors
`ifndef RMSEL_REGS_SVH
`define RMSEL_REGS_SVH

// ****************************************************************
// Register map (word index on the plain register port)
// ****************************************************************
`define RMSEL_ADDR_W       4
`define RMSEL_DATA_W       16
`define RMSEL_ADDR_SYNC    4'h0
`define RMSEL_ADDR_FAULT   4'h1

// ****************************************************************
// Field positions
// ****************************************************************
`define RMSEL_SYNC2_MSB    7
`define RMSEL_SYNC2_LSB    0
`define RMSEL_UPPER_MSB    15
`define RMSEL_UPPER_LSB    8
`define RMSEL_FAULT6_MSB   15
`define RMSEL_FAULT6_LSB   8
`define RMSEL_FAULT5_MSB   7
`define RMSEL_FAULT5_LSB   0

// ****************************************************************
// Selector codes and reset values
// ****************************************************************
`define RMSEL_SEL_W        8
`define RMSEL_SEL_GROUND   8'h00
`define RMSEL_SEL_PIN1     8'h01
`define RMSEL_SEL_PIN180   8'hB4
`define RMSEL_SEL_MAX      8'hB5
`define RMSEL_SEL_RESET    8'h00
`define RMSEL_UPPER_ZERO   8'h00
`define RMSEL_DATA_ZERO    16'h0000
`define RMSEL_PIN_COUNT    182

`endif

// *** inc/rmsel_pkg.sv ***
// Types shared by the remappable input selector block
`default_nettype none

package rmsel_pkg;
   `include "rmsel_regs.svh"

   // One selector code
   typedef logic [`RMSEL_SEL_W-1:0] rmsel_sel_t;

   // Remappable pin bus; bit 0 has no pin behind it
   typedef logic [`RMSEL_PIN_COUNT-1:0] rmsel_pins_t;

   // Request on the register port
   typedef struct packed {
      logic                     wrEn;
      logic                     rdEn;
      logic [`RMSEL_ADDR_W-1:0] addr;
      logic [`RMSEL_DATA_W-1:0] wrData;
   } rmsel_bus_s;

   // Routed peripheral inputs
   typedef struct packed {
      logic syncIn2;
      logic faultIn6;
      logic faultIn5;
   } rmsel_route_s;
endpackage

`default_nettype wire

// *** core/rmsel_mux.sv ***
// One selector-driven pin multiplexer with ground tie for code zero
`timescale 1ns/1ps
`default_nettype none
`include "rmsel_regs.svh"

module rmsel_mux
   import rmsel_pkg::*;
(
   input  wire rmsel_sel_t  sel,      // Selector code
   input  wire rmsel_pins_t pins,     // Remappable pins
   output logic             pinOut    // Selected level
);

   // ****************************************************************
   // Selection
   // ****************************************************************

   // Code zero ties to ground; codes past the last pin also read low
   // so an unsupported code can never pick up a floating bit
   always_comb begin
      if (sel == `RMSEL_SEL_GROUND || sel > `RMSEL_SEL_MAX) begin
         pinOut = 1'b0;
      end else begin
         pinOut = pins[sel];
      end
   end

endmodule
`default_nettype wire

// *** core/rmsel_top.sv ***
// Remappable pin selectors for PWM sync input 2 and fault inputs 5 and 6
`timescale 1ns/1ps
`default_nettype none
`include "rmsel_regs.svh"

module rmsel_top
   import rmsel_pkg::*;
(
   input  wire logic        clk,            // 25 MHz system clock
   input  wire logic        arst_n,         // Asynchronous reset, active low
   input  wire rmsel_bus_s  busReq,         // Register port request
   output logic [`RMSEL_DATA_W-1:0] rdData, // Read data, cycle after strobe
   input  wire rmsel_pins_t remappablePinN, // Remappable pin levels
   output var rmsel_route_s routed          // Routed PWM inputs
);

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Address match; used by both the write and the read path
   function automatic logic isAddr(input logic [`RMSEL_ADDR_W-1:0] a,
                                   input logic [`RMSEL_ADDR_W-1:0] target);
      isAddr = (a == target);
   endfunction

   // ****************************************************************
   // Selector registers
   // ****************************************************************

   rmsel_sel_t syncInPinSel;       // sync_in2_pin_sel
   rmsel_sel_t faultIn6PinSel;     // fault_in6_pin_sel
   rmsel_sel_t faultIn5PinSel;     // fault_in5_pin_sel
   rmsel_sel_t next_syncInPinSel;
   rmsel_sel_t next_faultIn6PinSel;
   rmsel_sel_t next_faultIn5PinSel;

   // Next selector values from a write strobe
   always_comb begin
      next_syncInPinSel   = syncInPinSel;
      next_faultIn6PinSel = faultIn6PinSel;
      next_faultIn5PinSel = faultIn5PinSel;
      if (busReq.wrEn) begin
         if (isAddr(busReq.addr, `RMSEL_ADDR_SYNC)) begin
            // Upper byte is not stored, so writes to it vanish
            next_syncInPinSel =
               busReq.wrData[`RMSEL_SYNC2_MSB:`RMSEL_SYNC2_LSB];
         end else if (isAddr(busReq.addr, `RMSEL_ADDR_FAULT)) begin
            next_faultIn6PinSel =
               busReq.wrData[`RMSEL_FAULT6_MSB:`RMSEL_FAULT6_LSB];
            next_faultIn5PinSel =
               busReq.wrData[`RMSEL_FAULT5_MSB:`RMSEL_FAULT5_LSB];
         end
      end
   end

   // Register the selectors; reset leaves every input grounded
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         syncInPinSel   <= `RMSEL_SEL_RESET;
         faultIn6PinSel <= `RMSEL_SEL_RESET;
         faultIn5PinSel <= `RMSEL_SEL_RESET;
      end else begin
         syncInPinSel   <= next_syncInPinSel;
         faultIn6PinSel <= next_faultIn6PinSel;
         faultIn5PinSel <= next_faultIn5PinSel;
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************

   logic [`RMSEL_DATA_W-1:0] next_rdData;

   // Read data stands only in the cycle after the strobe; unmapped
   // addresses and idle cycles read zero
   always_comb begin
      next_rdData = `RMSEL_DATA_ZERO;
      if (busReq.rdEn) begin
         if (isAddr(busReq.addr, `RMSEL_ADDR_SYNC)) begin
            next_rdData = {`RMSEL_UPPER_ZERO, syncInPinSel};
         end else if (isAddr(busReq.addr, `RMSEL_ADDR_FAULT)) begin
            next_rdData = {faultIn6PinSel, faultIn5PinSel};
         end
      end
   end

   // Read data register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdData <= `RMSEL_DATA_ZERO;
      end else begin
         rdData <= next_rdData;
      end
   end

   // ****************************************************************
   // Pin routing
   // ****************************************************************

   rmsel_route_s muxed;          // Combinational mux results
   rmsel_route_s next_routed;

   // Sync input 2 multiplexer
   rmsel_mux u_syncMux (
      .sel    (syncInPinSel),
      .pins   (remappablePinN),
      .pinOut (muxed.syncIn2)
   );

   // Fault input 6 multiplexer
   rmsel_mux u_fault6Mux (
      .sel    (faultIn6PinSel),
      .pins   (remappablePinN),
      .pinOut (muxed.faultIn6)
   );

   // Fault input 5 multiplexer
   rmsel_mux u_fault5Mux (
      .sel    (faultIn5PinSel),
      .pins   (remappablePinN),
      .pinOut (muxed.faultIn5)
   );

   // Next routed levels; a flop stage costs one cycle of latency but
   // keeps the wide mux off the PWM side timing path
   always_comb begin
      next_routed = muxed;
   end

   // Routed outputs register; ground level during reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         routed <= '0;
      end else begin
         routed <= next_routed;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************

   a_fault6_write:
   assert property (@(posedge clk) disable iff (!arst_n)
      busReq.wrEn && busReq.addr == `RMSEL_ADDR_FAULT |=>
      faultIn6PinSel == $past(busReq.wrData[`RMSEL_FAULT6_MSB:`RMSEL_FAULT6_LSB]))
      else $error("fault 6 selector not written");

   a_fault5_write:
   assert property (@(posedge clk) disable iff (!arst_n)
      busReq.wrEn && busReq.addr == `RMSEL_ADDR_FAULT |=>
      faultIn5PinSel == $past(busReq.wrData[`RMSEL_FAULT5_MSB:`RMSEL_FAULT5_LSB]))
      else $error("fault 5 selector not written");

   a_sync_write:
   assert property (@(posedge clk) disable iff (!arst_n)
      busReq.wrEn && busReq.addr == `RMSEL_ADDR_SYNC |=>
      syncInPinSel == $past(busReq.wrData[`RMSEL_SYNC2_MSB:`RMSEL_SYNC2_LSB]))
      else $error("sync selector not written");

   a_pin_route:
   assert property (@(posedge clk) disable iff (!arst_n)
      faultIn5PinSel != `RMSEL_SEL_GROUND && faultIn5PinSel <= `RMSEL_SEL_MAX |=>
      routed.faultIn5 == $past(remappablePinN[faultIn5PinSel]))
      else $error("fault 5 not routed from selected pin");

   a_pin_last:
   assert property (@(posedge clk) disable iff (!arst_n)
      faultIn6PinSel == `RMSEL_SEL_MAX |=>
      routed.faultIn6 == $past(remappablePinN[`RMSEL_PIN_COUNT-1]))
      else $error("last code not routed to last pin");

   a_pin_one:
   assert property (@(posedge clk) disable iff (!arst_n)
      syncInPinSel == `RMSEL_SEL_PIN1 |=> routed.syncIn2 == $past(remappablePinN[1]))
      else $error("code one not routed to pin one");

   a_ground_tie:
   assert property (@(posedge clk) disable iff (!arst_n)
      faultIn6PinSel == `RMSEL_SEL_GROUND |=> !routed.faultIn6)
      else $error("grounded fault 6 input not low");

   a_sync_ground:
   assert property (@(posedge clk) disable iff (!arst_n)
      syncInPinSel == `RMSEL_SEL_GROUND |=> !routed.syncIn2)
      else $error("grounded sync input not low");

   a_fault5_ground:
   assert property (@(posedge clk) disable iff (!arst_n)
      faultIn5PinSel == `RMSEL_SEL_GROUND |=> !routed.faultIn5)
      else $error("grounded fault 5 input not low");

   a_upper_zero:
   assert property (@(posedge clk) disable iff (!arst_n)
      busReq.rdEn && busReq.addr == `RMSEL_ADDR_SYNC |=>
      rdData[`RMSEL_UPPER_MSB:`RMSEL_UPPER_LSB] == `RMSEL_UPPER_ZERO
      && rdData[`RMSEL_SYNC2_MSB:`RMSEL_SYNC2_LSB] == $past(syncInPinSel))
      else $error("sync read back wrong");

   a_fault_read:
   assert property (@(posedge clk) disable iff (!arst_n)
      busReq.rdEn && busReq.addr == `RMSEL_ADDR_FAULT |=>
      rdData == $past({faultIn6PinSel, faultIn5PinSel}))
      else $error("fault select read back wrong");

   c_sync_pin180: cover property (@(posedge clk) disable iff (!arst_n)
      syncInPinSel == `RMSEL_SEL_PIN180 ##1 routed.syncIn2);
   c_fault6_route: cover property (@(posedge clk) disable iff (!arst_n)
      faultIn6PinSel != `RMSEL_SEL_GROUND ##1 routed.faultIn6);
   c_write_read: cover property (@(posedge clk) disable iff (!arst_n)
      busReq.wrEn ##1 busReq.rdEn);
   c_fault5_ground: cover property (@(posedge clk) disable iff (!arst_n)
      faultIn5PinSel == `RMSEL_SEL_GROUND && remappablePinN[1] ##1 !routed.faultIn5);

endmodule
`default_nettype wire

// *** sim/rmsel_top_tb.sv ***
// Self-checking bench for the remappable PWM sync and fault input selectors
`timescale 1ns/1ps
`default_nettype none
`include "rmsel_regs.svh"

module rmsel_top_tb
   import rmsel_pkg::*;
;
   // ****************************************************************
   // Signals and scoreboard
   // ****************************************************************
   logic                     clk;            // 25 MHz clock
   logic                     arst_n;         // Active-low reset
   rmsel_bus_s               busReq;         // Register port request
   logic [`RMSEL_DATA_W-1:0] rdData;         // Read data from the block
   rmsel_pins_t              pins;           // Remappable pin levels
   rmsel_route_s             routed;         // Routed PWM inputs
   logic                     rtChk;          // Compare routed at next edge
   logic                     rdPrev;         // Read strobe taken last edge
   logic [31:0]              lfsr = 32'hA388; // Random source state
   int                       badCount = 0;   // Mismatches seen
   int                       cmpCount = 0;   // Comparisons made
   logic [15:0]              rdQ[$];         // Expected read data
   rmsel_route_s             rtQ[$];         // Expected routed levels
   rmsel_sel_t               codes[6];       // Codes every selector gets

   rmsel_top dut (
      .clk            (clk),
      .arst_n         (arst_n),
      .busReq         (busReq),
      .rdData         (rdData),
      .remappablePinN (pins),
      .routed         (routed)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Fibonacci-style shift register step
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction

   // Level a selector should deliver; zero and codes past the top ground it
   function automatic logic pick(rmsel_pins_t p, rmsel_sel_t s);
      return (s == `RMSEL_SEL_GROUND || s > `RMSEL_SEL_MAX) ? 1'b0 : p[s];
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         badCount++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic completeRun();
      $display("comparisons %0d mismatches %0d", cmpCount, badCount);
      if (badCount == 0 && cmpCount > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      busReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
   endtask

   // One-cycle read strobe; noise on write data must not matter
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      busReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 16'(rnd())};
      rdQ.push_back(e);
   endtask

   // Park the port and ask the monitor to look at routed
   task automatic expectRoute(input rmsel_route_s e);
      @(posedge clk);
      busReq <= '0;
      rtChk  <= 1'b1;
      rtQ.push_back(e);
      @(posedge clk);
      rtChk  <= 1'b0;
   endtask

   // Program all three selectors, then route a pattern and its inverse
   task automatic route(input rmsel_sel_t s, input rmsel_sel_t f6, input rmsel_sel_t f5);
      rmsel_pins_t p;
      p = rmsel_pins_t'({rnd(), rnd(), rnd(), rnd(), rnd(), rnd()});
      wr(`RMSEL_ADDR_SYNC, {8'(rnd()), s});
      wr(`RMSEL_ADDR_FAULT, {f6, f5});
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         busReq <= '0;
         pins   <= p;
         expectRoute('{syncIn2: pick(p, s), faultIn6: pick(p, f6), faultIn5: pick(p, f5)});
         p = ~p;
      end
      // Upper sync byte was written with noise and must read zero
      rd(`RMSEL_ADDR_SYNC, {`RMSEL_UPPER_ZERO, s});
      rd(`RMSEL_ADDR_FAULT, {f6, f5});
   endtask

   // ****************************************************************
   // Monitor: read data stands only in the cycle after the strobe
   // ****************************************************************
   always @(posedge clk) begin
      if (rdPrev) begin
         chk(rdData, rdQ.pop_front());
      end
      if (rtChk) begin
         chk({13'h0, routed}, {13'h0, rtQ.pop_front()});
      end
      rdPrev <= busReq.rdEn;
   end

   // ****************************************************************
   // Clock, stimulus and watchdog
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      arst_n = 1'b0;
      busReq = '0;
      pins   = '1;
      rtChk  = 1'b0;
      rdPrev = 1'b0;
      codes  = '{`RMSEL_SEL_GROUND, `RMSEL_SEL_PIN1, `RMSEL_SEL_PIN180,
                 `RMSEL_SEL_MAX, 8'h5A, 8'hC7};
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      // Reset state: selectors zero, inputs grounded though pins are high
      rd(`RMSEL_ADDR_SYNC, `RMSEL_DATA_ZERO);
      rd(`RMSEL_ADDR_FAULT, `RMSEL_DATA_ZERO);
      expectRoute('0);
      // Unmapped place: write lost, read zero, mapped fault register untouched
      wr(4'hF, 16'hFFFF);
      rd(4'hF, `RMSEL_DATA_ZERO);
      rd(`RMSEL_ADDR_FAULT, `RMSEL_DATA_ZERO);
      // Every code on every selector, one random pin code per pass
      for (int i = 0; i < 12; i++) begin
         codes[4] = 8'(rnd() % 181 + 1);
         route(codes[i % 6], codes[(i + 1) % 6], codes[(i + 2) % 6]);
      end
      // Mid-run reset: sync and fault 5 selectors left non-zero must clear and ground again;
      // the port is parked first so the last read lands before reset
      @(posedge clk);
      busReq <= '0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b0;
      pins   <= '1;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      rd(`RMSEL_ADDR_SYNC, `RMSEL_DATA_ZERO);
      rd(`RMSEL_ADDR_FAULT, `RMSEL_DATA_ZERO);
      expectRoute('0);
      // Let the monitor take the last notes before the verdict
      repeat (3) @(posedge clk);
      chk(16'(rdQ.size() + rtQ.size()), 16'h0000);
      completeRun();
   end

   // Whole run needs about 140 cycles; a hang is cut well after
   initial begin
      repeat (3000) @(posedge clk);
      badCount++;
      completeRun();
   end
endmodule

`default_nettype wire
